// ---- spi_host_pkg.sv ----
// package for the serial configuration host controller
// assumes one 25 MHz clock domain on the controller side
package spi_host_pkg;
    // device register offsets (15-bit address space)
    localparam logic [14:0] ADDR_NV_CYCLE_COUNT   = 15'h0010;
    localparam logic [14:0] ADDR_OVERLAY_CTRL     = 15'h0014;
    localparam logic [14:0] ADDR_SOFT_SYNC_CTRL   = 15'h0015;
    localparam logic [14:0] ADDR_GLOBAL_RESET     = 15'h0017;
    localparam logic [14:0] ADDR_SYNC_ENABLE      = 15'h0019;
    localparam logic [14:0] ADDR_NV_COMMAND       = 15'h00ab;
    localparam logic [14:0] ADDR_NV_UNLOCK        = 15'h00b4;
    // command/status field positions
    localparam int BIT_NV_PROGRAM   = 0;
    localparam int BIT_NV_ERASE     = 1;
    localparam int BIT_NV_BUSY      = 2;
    localparam int BIT_COMMIT       = 6;
    localparam int BIT_OVERLAY      = 7;
    localparam int BIT_GLOBAL_RESET = 6;
    localparam int BIT_SOFT_SYNC    = 6;
    localparam int BIT_SYNC_ENABLE  = 0;
    localparam logic [7:0] NV_UNLOCK_VALUE = 8'hea;
    localparam logic [7:0] NV_LOCK_VALUE   = 8'h00;
    localparam logic       DIR_WRITE = 1'b0;
    localparam logic       DIR_READ  = 1'b1;
    // frame layout
    localparam int HDR_BITS  = 16;
    localparam int DATA_BITS = 8;
    // timing: sck period from divider
    localparam int CLK_MHZ        = 25;
    localparam int SCK_HALF_NS    = 160;
    localparam int SCK_HALF_CYC   = (SCK_HALF_NS * CLK_MHZ + 999) / 1000;
    localparam int CS_GAP_NS      = 200;
    localparam int CS_GAP_CYC     = (CS_GAP_NS * CLK_MHZ + 999) / 1000;
    // own host registers (software side)
    localparam logic [3:0] HREG_CTRL    = 4'h0;
    localparam logic [3:0] HREG_ADDR    = 4'h1;
    localparam logic [3:0] HREG_WDATA   = 4'h2;
    localparam logic [3:0] HREG_COUNT   = 4'h3;
    localparam logic [3:0] HREG_STATUS  = 4'h4;
    localparam logic [3:0] HREG_RDATA   = 4'h5;
    localparam logic [3:0] HREG_CONFIG  = 4'h6;
    localparam logic [3:0] HREG_SEQ     = 4'h7;
    // ctrl bits
    localparam int CTRL_START = 0;
    localparam int CTRL_READ  = 1;
    // seq opcodes
    localparam logic [1:0] SEQ_NONE    = 2'd0;
    localparam logic [1:0] SEQ_RESETS  = 2'd1;
    localparam logic [1:0] SEQ_PROGRAM = 2'd2;
    localparam logic [1:0] SEQ_SYNC    = 2'd3;
endpackage

// ---- spi_cfg_host.sv ----
// host controller driving the clock synchronizer's serial control port as SPI host
// assumes software on a plain strobe port; device pins sampled through two flops
// Behaviour
// (R1) every access: two address bytes then one data byte
// (R2) three-wire mode: data sent and received on one shared data pin
// (R3) four-wire mode: read data taken from separate serial output pin
// (R4) host sends msb first: direction, 15-bit address, 8-bit data
// (R5) direction bit 0 writes, 1 reads
// (R6) frame begins with chip select low, ends with it high
// (R7) device commits each whole byte on sck rising edge; partial bytes lost
// (R8) device shifts read data on sck falling edges
// (R9) block transfers give lowest address; device increments per extra byte
// (R10) device samples interface-select pin at power-on to pick i2c or spi
// (R11) i2c client supports standard and fast mode
// (R12) device loads upper five i2c address bits from nonvolatile memory
// (R13) low two i2c address bits come from address pin level
// (R14) host sets global reset, then loop resets, then clears global reset; the sequence here sets and clears global reset with no loop resets
// (R15) interrupt flags are sticky until software clears them
// (R16) commit bit copies active registers to staging, then self-clears
// (R17) overlay-enable bit makes next power-on load the nonvolatile image
// (R18) host unlocks with 234, relocks with 0 afterwards
// (R19) host writes erase and program together right after unlock
// (R20) busy high during programming; host polls before relocking
// (R21) device counts successful programming cycles at next power-on
// (R22) direct staging writes leave active registers untouched
// (R23) commit fill never alters address-bits and revision bytes
// (R24) host raises sync enable and software sync, then drops software sync
// (R25) device ignores commands while busy and clears them on completion
//
// Decided for this implementation: strobed register access.
`timescale 1ns/10ps
module spi_cfg_host (
    input  wire logic        i_clk,
    input  wire logic        i_rst,
    input  wire logic [3:0]  i_addr,
    input  wire logic [15:0] i_wdata,
    input  wire logic        i_wr,
    input  wire logic        i_rd,
    output logic      [15:0] o_rdata,
    output logic             o_sck,
    output logic             o_cs_n,
    output logic             o_sdio_out,
    output logic             o_sdio_oe_n,
    input  wire logic        i_sdio_in,
    input  wire logic        i_sdo_in
);
    import spi_host_pkg::*;

    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_NEXT = 3'b001,
        ST_LOW  = 3'b011,
        ST_HIGH = 3'b010,
        ST_GAP  = 3'b110
    } state_t;

    typedef struct packed {
        state_t      st;
        logic [15:0] rdata_out;
        logic        sck;
        logic        cs_n;
        logic        sdo;
        logic        oe_n;
        logic        sync1;
        logic        sync2;
        logic        so1;
        logic        so2;
        logic [14:0] reg_addr;
        logic [7:0]  wdata;
        logic        dir;
        logic [7:0]  count;
        logic [7:0]  left;
        logic [23:0] shift;
        logic [4:0]  bitn;
        logic [3:0]  div;
        logic [7:0]  rdbyte;
        logic        rd_valid;
        logic        four_wire;
        logic        busy;
        logic [1:0]  seq;
        logic [2:0]  step;
        logic        busy_seen;
    } state_s_t;

    state_s_t q, d;

    // one scripted step of a built-in sequence: dir, addr, data
    function automatic logic [23:0] seq_word(input logic [1:0] s, input logic [2:0] k);
        logic [23:0] w;
        w = 24'h000000;
        case (s)
            SEQ_RESETS: begin
                case (k)
                    3'd0:    w = {DIR_WRITE, ADDR_GLOBAL_RESET, 8'(1 << BIT_GLOBAL_RESET)};    // [R14]
                    default: w = {DIR_WRITE, ADDR_GLOBAL_RESET, 8'h00};                         // [R14]
                endcase
            end
            SEQ_PROGRAM: begin
                case (k)
                    3'd0:    w = {DIR_WRITE, ADDR_NV_COMMAND, 8'(1 << BIT_COMMIT)};
                    3'd1:    w = {DIR_WRITE, ADDR_OVERLAY_CTRL, 8'(1 << BIT_OVERLAY)};
                    3'd2:    w = {DIR_WRITE, ADDR_NV_UNLOCK, NV_UNLOCK_VALUE};                  // [R18]
                    3'd3:    w = {DIR_WRITE, ADDR_NV_COMMAND,
                                  8'((1 << BIT_NV_ERASE) | (1 << BIT_NV_PROGRAM))};            // [R19]
                    3'd4:    w = {DIR_READ, ADDR_NV_COMMAND, 8'h00};                            // [R20]
                    default: w = {DIR_WRITE, ADDR_NV_UNLOCK, NV_LOCK_VALUE};                    // [R18]
                endcase
            end
            SEQ_SYNC: begin
                case (k)
                    3'd0:    w = {DIR_WRITE, ADDR_SYNC_ENABLE, 8'(1 << BIT_SYNC_ENABLE)};      // [R24]
                    3'd1:    w = {DIR_WRITE, ADDR_SOFT_SYNC_CTRL, 8'(1 << BIT_SOFT_SYNC)};     // [R24]
                    default: w = {DIR_WRITE, ADDR_SOFT_SYNC_CTRL, 8'h00};                       // [R24]
                endcase
            end
            default: w = 24'h000000;
        endcase
        return w;
    endfunction

    function automatic logic [2:0] seq_len(input logic [1:0] s);
        case (s)
            SEQ_RESETS:  return 3'd2;
            SEQ_PROGRAM: return 3'd6;
            SEQ_SYNC:    return 3'd3;
            default:     return 3'd0;
        endcase
    endfunction

    logic        rx_bit;
    logic [23:0] sw;

    always_comb begin
        d = q;
        sw = 24'h000000;
        d.sync1 = i_sdio_in;
        d.sync2 = q.sync1;
        d.so1   = i_sdo_in;
        d.so2   = q.so1;
        rx_bit  = q.four_wire ? q.so2 : q.sync2;                                  // [R2] [R3]
        d.rdata_out = 16'h0000;
        // software register reads: data in the following cycle
        if (i_rd) begin
            case (i_addr)
                HREG_ADDR:   d.rdata_out = {1'b0, q.reg_addr};
                HREG_WDATA:  d.rdata_out = {8'h00, q.wdata};
                HREG_COUNT:  d.rdata_out = {8'h00, q.count};
                HREG_STATUS: d.rdata_out = {13'h0000, q.busy_seen, q.rd_valid, q.busy};
                HREG_RDATA:  d.rdata_out = {8'h00, q.rdbyte};
                HREG_CONFIG: d.rdata_out = {15'h0000, q.four_wire};
                HREG_SEQ:    d.rdata_out = {11'h000, q.step, q.seq};
                default:     d.rdata_out = 16'h0000;
            endcase
        end
        if (i_wr && !q.busy) begin
            case (i_addr)
                HREG_ADDR:   d.reg_addr  = i_wdata[14:0];
                HREG_WDATA:  d.wdata     = i_wdata[7:0];
                HREG_COUNT:  d.count     = i_wdata[7:0];
                HREG_CONFIG: d.four_wire = i_wdata[0];
                HREG_CTRL: begin
                    if (i_wdata[CTRL_START]) begin
                        d.dir  = i_wdata[CTRL_READ] ? DIR_READ : DIR_WRITE;         // [R5]
                        d.busy = 1'b1;
                        d.rd_valid = 1'b0;
                        d.seq  = SEQ_NONE;
                        d.st   = ST_NEXT;
                    end
                end
                HREG_SEQ: begin
                    if (seq_len(i_wdata[1:0]) != 3'd0) begin
                        d.seq  = i_wdata[1:0];
                        d.step = 3'd0;
                        d.busy = 1'b1;
                        d.busy_seen = 1'b0;
                        d.st   = ST_NEXT;
                    end
                end
                default: ;
            endcase
        end
        case (q.st)
            ST_IDLE: begin
                d.cs_n = 1'b1;
                d.sck  = 1'b0;
                d.oe_n = 1'b1;
            end
            ST_NEXT: begin
                // load header and first data byte, then open the frame
                if (q.seq != SEQ_NONE) begin
                    sw = seq_word(q.seq, q.step);
                    d.dir = sw[23];
                    d.shift = sw;
                    d.left = 8'h00;                                               // single access per step [R1]
                end else begin
                    d.shift = {q.dir, q.reg_addr, q.wdata};                      // [R1] [R4]
                    d.left  = q.count;                                            // extra bytes in block [R9]
                end
                d.bitn = 5'd0;
                d.div  = 4'h0;
                d.cs_n = 1'b0;                                                    // [R6]
                d.sck  = 1'b0;
                d.sdo  = q.seq != SEQ_NONE ? sw[23] : q.dir;
                d.oe_n = 1'b0;
                d.st   = ST_LOW;
            end
            ST_LOW: begin
                d.div = q.div + 4'h1;
                if (q.div == 4'(SCK_HALF_CYC - 1)) begin
                    d.div = 4'h0;
                    d.sck = 1'b1;                                                 // device samples here [R7]
                    d.st  = ST_HIGH;
                end
            end
            ST_HIGH: begin
                d.div = q.div + 4'h1;
                if (q.div == 4'(SCK_HALF_CYC - 1)) begin
                    d.div = 4'h0;
                    d.sck = 1'b0;                                                 // device drives on this edge [R8]
                    // capture read bit from the device at end of high phase
                    if (q.dir == DIR_READ && q.bitn >= 5'(HDR_BITS))
                        d.rdbyte = {q.rdbyte[6:0], rx_bit};
                    d.shift = {q.shift[22:0], 1'b0};                              // msb first [R4]
                    d.sdo   = q.shift[22];
                    if (q.bitn == 5'(HDR_BITS - 1) && q.dir == DIR_READ)
                        d.oe_n = q.four_wire ? 1'b0 : 1'b1;                       // release shared pin [R2]
                    d.bitn = q.bitn + 5'd1;
                    d.st   = ST_LOW;
                    if (q.bitn == 5'(HDR_BITS + DATA_BITS - 1)) begin
                        if (q.dir == DIR_READ)
                            d.rd_valid = 1'b1;
                        if (q.left != 8'h00) begin
                            // stay selected; device advances its pointer [R9]
                            d.left  = q.left - 8'h01;
                            d.bitn  = 5'(HDR_BITS);
                            d.shift = {q.wdata, 16'h0000};
                            d.sdo   = q.wdata[7];
                        end else begin
                            d.st = ST_GAP;                                        // whole bytes only [R7]
                        end
                    end
                end
            end
            ST_GAP: begin
                d.cs_n = 1'b1;                                                    // [R6]
                d.oe_n = 1'b1;
                d.div  = q.div + 4'h1;
                if (q.div == 4'(CS_GAP_CYC)) begin
                    d.div = 4'h0;
                    d.st  = ST_IDLE;
                    d.busy = 1'b0;
                    if (q.seq != SEQ_NONE) begin
                        d.busy = 1'b1;
                        d.st   = ST_NEXT;
                        if (q.seq == SEQ_PROGRAM && q.step == 3'd4) begin
                            // poll busy flag until it drops [R20]
                            if (q.rdbyte[BIT_NV_BUSY])
                                d.busy_seen = 1'b1;
                            else
                                d.step = 3'd5;
                        end else if (q.step + 3'd1 == seq_len(q.seq)) begin
                            d.seq  = SEQ_NONE;
                            d.busy = 1'b0;
                            d.st   = ST_IDLE;
                        end else begin
                            d.step = q.step + 3'd1;
                        end
                    end
                end
            end
            default: d.st = ST_IDLE;
        endcase
        if (i_rst) begin
            d = '0;
            d.st   = ST_IDLE;
            d.cs_n = 1'b1;
            d.oe_n = 1'b1;
            d.sync1 = 1'b0;
        end
    end

    always_ff @(posedge i_clk) begin
        q <= d;
    end

    assign o_rdata     = q.rdata_out;
    assign o_sck       = q.sck;
    assign o_cs_n      = q.cs_n;
    assign o_sdio_out  = q.sdo;
    assign o_sdio_oe_n = q.oe_n;
endmodule // spi_cfg_host

// ---- spi_cfg_host_chk.sv ----
// checker: frame shape of the serial host at its pins
// assumes a bind onto spi_cfg_host and a single clock domain
`timescale 1ns/10ps
module spi_cfg_host_chk (
    input wire logic        i_clk,
    input wire logic        i_rst,
    input wire logic [3:0]  i_addr,
    input wire logic [15:0] i_wdata,
    input wire logic        i_wr,
    input wire logic        i_rd,
    input wire logic [15:0] o_rdata,
    input wire logic        o_sck,
    input wire logic        o_cs_n,
    input wire logic        o_sdio_out,
    input wire logic        o_sdio_oe_n,
    input wire logic        i_sdio_in,
    input wire logic        i_sdo_in
);
    logic [7:0] rises_q;
    logic       sck_q;
    // counts sck rising edges inside the current frame
    always_ff @(posedge i_clk) begin
        sck_q <= o_sck;
        if (i_rst || o_cs_n) begin
            rises_q <= 8'h00;
        end else if (o_sck && !sck_q) begin
            rises_q <= rises_q + 8'h01;
        end
    end
    default clocking @(posedge i_clk); endclocking
    default disable iff (i_rst);
    property p_sck_idle; o_cs_n |-> !o_sck; endproperty
    property p_cs_lead; $fell(o_cs_n) |-> !o_sck [*4] ##1 o_sck; endproperty
    property p_cs_gap; $rose(o_cs_n) |-> o_cs_n [*6]; endproperty
    property p_sck_high; $rose(o_sck) |-> o_sck [*4] ##1 !o_sck; endproperty
    property p_sck_low; $fell(o_sck) |-> !o_sck [*4]; endproperty
    property p_sdo_stable; $rose(o_sck) && !o_sdio_oe_n |-> $stable(o_sdio_out); endproperty
    property p_whole_bytes; $rose(o_cs_n) |-> rises_q >= 8'd24 && rises_q[2:0] == 3'h0; endproperty
    property p_oe_idle; o_cs_n |-> o_sdio_oe_n; endproperty
    property p_rd_release; $rose(o_sdio_oe_n) && !o_cs_n |-> rises_q == 8'd16; endproperty
    a_sck_idle: assert property (p_sck_idle) else $error("sck moved outside a frame");
    a_cs_lead: assert property (p_cs_lead) else $error("first sck edge not 4 cycles after select");
    a_cs_gap: assert property (p_cs_gap) else $error("chip select gap too short");
    a_sck_high: assert property (p_sck_high) else $error("sck high phase not 4 cycles");
    a_sck_low: assert property (p_sck_low) else $error("sck low phase too short");
    a_sdo_stable: assert property (p_sdo_stable) else $error("data changed at sck rise");
    a_whole_bytes: assert property (p_whole_bytes) else $error("frame not whole bytes");
    a_oe_idle: assert property (p_oe_idle) else $error("data pin driven outside a frame");
    a_rd_release: assert property (p_rd_release) else $error("data pin released at wrong bit");
    c_write: cover property ($rose(o_cs_n) && rises_q == 8'd24);
    c_block: cover property ($rose(o_cs_n) && rises_q > 8'd24);
    c_read: cover property ($rose(o_sdio_oe_n) && !o_cs_n);
endmodule // spi_cfg_host_chk
bind spi_cfg_host spi_cfg_host_chk u_chk (.i_clk(i_clk), .i_rst(i_rst), .i_addr(i_addr),
    .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .o_sck(o_sck), .o_cs_n(o_cs_n),
    .o_sdio_out(o_sdio_out), .o_sdio_oe_n(o_sdio_oe_n), .i_sdio_in(i_sdio_in), .i_sdo_in(i_sdo_in));

// ---- spi_dev_model.sv ----
// behavioural serial device: register image and nonvolatile command flow
// assumes sck, chip select and the shared data line come from the host
`timescale 1ns/10ps
module spi_dev_model #(parameter int BUSY_CYC = 400) (
    input  wire logic i_clk,
    input  wire logic i_sck,
    input  wire logic i_cs_n,
    input  wire logic i_host_out,
    input  wire logic i_host_oe_n,
    input  wire logic i_four_wire,
    output logic      o_sdio,
    output logic      o_sdo
);
    import spi_host_pkg::*;
    logic [7:0]  mem [0:255];
    logic [15:0] sh;
    logic [14:0] ptr, last_wr;
    logic [7:0]  q;
    logic        rd, dq, den;
    int          n, progs, grst_sets;
    // released lines show the inverse of the last bit
    assign o_sdio = !i_host_oe_n ? i_host_out : (den && !i_four_wire) ? dq : ~dq;
    assign o_sdo  = (den && i_four_wire) ? dq : ~dq;
    initial begin
        foreach (mem[i]) mem[i] = 8'h00;
        {dq, den, rd, n, progs, grst_sets, last_wr} = '0;
    end
    task automatic store(input logic [14:0] a, input logic [7:0] d);
        logic ok;
        ok = !mem[8'hab][BIT_NV_BUSY] && mem[8'hb4] == NV_UNLOCK_VALUE;
        if (a == ADDR_NV_COMMAND) begin
            mem[8'hab][7:3] = d[7:3];
            if (ok) mem[8'hab][1:0] = d[1:0];
            if (ok && d[1:0] == 2'b11 && last_wr == ADDR_NV_UNLOCK) begin
                progs++;
                mem[8'hab][BIT_NV_BUSY] = 1'b1;
                fork begin
                    repeat (BUSY_CYC) @(posedge i_clk);
                    mem[8'hab][2:0] = 3'h0;
                end join_none
            end
            // commit bit self-clears 8 clocks later; no staging fill is modelled
            if (d[BIT_COMMIT]) fork begin
                repeat (8) @(posedge i_clk);
                mem[8'hab][BIT_COMMIT] = 1'b0;
            end join_none
        end else if (a != ADDR_NV_CYCLE_COUNT) mem[a[7:0]] = d;
        if (a == ADDR_GLOBAL_RESET && d[BIT_GLOBAL_RESET]) grst_sets++;
        last_wr = a;
    endtask
    // strapped for spi at power-on; i2c addressing and interrupt flags not modelled
    always @(negedge i_cs_n) n = 0;
    always @(posedge i_cs_n) den = 1'b0;
    always @(posedge i_sck) if (!i_cs_n) begin
        sh = {sh[14:0], o_sdio};
        n++;
        if (n == 16) begin
            rd = sh[15];
            ptr = sh[14:0];
        end else if (n > 16 && n % 8 == 0) begin
            if (!rd) store(ptr, sh[7:0]);
            ptr++;
        end
    end
    always @(negedge i_sck) if (!i_cs_n && rd && n >= 16) begin
        q = mem[ptr[7:0]];
        dq = q[7 - n % 8];
        den = 1'b1;
    end
endmodule // spi_dev_model

// ---- host_serial_cfg_nvm_access_tb.sv ----
// self-checking bench: software port tasks, read-data scoreboard, device model
// assumes the device model and the bound checker are compiled alongside
`timescale 1ns/10ps
module host_serial_cfg_nvm_access_tb;
    import spi_host_pkg::*;
    logic        i_clk, i_rst, i_wr, i_rd, rd_d, four_wire;
    logic        o_sck, o_cs_n, o_sdio_out, o_sdio_oe_n, sdio, sdo;
    logic [3:0]  i_addr;
    logic [15:0] i_wdata, o_rdata;
    logic [16:0] notes [$];
    logic [16:0] note;
    logic [7:0]  d, e;
    logic [14:0] regs [0:4] = '{ADDR_OVERLAY_CTRL, ADDR_SOFT_SYNC_CTRL, ADDR_GLOBAL_RESET, ADDR_SYNC_ENABLE, 15'h0030};
    int          failures, n_compared, seed;
    spi_cfg_host u_spi_cfg_host (.i_clk(i_clk), .i_rst(i_rst), .i_addr(i_addr), .i_wdata(i_wdata),
        .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .o_sck(o_sck), .o_cs_n(o_cs_n),
        .o_sdio_out(o_sdio_out), .o_sdio_oe_n(o_sdio_oe_n), .i_sdio_in(sdio), .i_sdo_in(sdo));
    spi_dev_model u_spi_dev_model (.i_clk(i_clk), .i_sck(o_sck), .i_cs_n(o_cs_n), .i_host_out(o_sdio_out),
        .i_host_oe_n(o_sdio_oe_n), .i_four_wire(four_wire), .o_sdio(sdio), .o_sdo(sdo));
    initial begin
        i_clk = 1'b0;
        forever #20 i_clk = ~i_clk;
    end
    task automatic chk(input logic [15:0] s, input logic [15:0] x);
        n_compared++;
        if (s !== x) begin
            failures++;
            $display("MISMATCH t=%0t seen %h expected %h", $time, s, x);
        end
    endtask
    task automatic conclude();
        $display("compared %0d failures %0d", n_compared, failures);
        if (failures == 0 && n_compared > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    // oldest note is matched against read data in the cycle after the strobe
    always @(posedge i_clk) begin
        if (rd_d) begin
            note = notes.pop_front();
            if (note[16]) chk(o_rdata, note[15:0]);
        end
        rd_d <= i_rd;
    end
    task automatic wr(input logic [3:0] a, input logic [15:0] v);
        @(posedge i_clk);
        i_wr <= 1'b1;
        i_addr <= a;
        i_wdata <= v;
        @(posedge i_clk);
        i_wr <= 1'b0;
    endtask
    task automatic rd(input logic [3:0] a, input logic use_it, input logic [15:0] x);
        notes.push_back({use_it, x});
        @(posedge i_clk);
        i_rd <= 1'b1;
        i_addr <= a;
        @(posedge i_clk);
        i_rd <= 1'b0;
    endtask
    task automatic wait_idle();
        for (int i = 0; i < 2000; i++) begin
            rd(HREG_STATUS, 1'b0, 16'h0000);
            @(negedge i_clk);
            if (o_rdata[0] === 1'b0) return;
        end
        failures++;
        conclude();
    endtask
    task automatic dev(input logic [14:0] a, input logic [7:0] v, input logic [15:0] cnt, input logic rdop);
        wr(HREG_ADDR, {1'b0, a});
        wr(HREG_WDATA, {8'h00, v});
        wr(HREG_COUNT, cnt);
        wr(HREG_CTRL, {14'h0, rdop, 1'b1});
        wait_idle();
    endtask
    initial begin
        {i_wr, i_rd, rd_d, four_wire, i_addr, i_wdata, failures, n_compared} = '0;
        i_rst = 1'b1;
        seed = $urandom(83879);
        repeat (8) @(posedge i_clk);
        i_rst <= 1'b0;
        chk({13'h0, o_cs_n, o_sck, o_sdio_oe_n}, 16'h0005);
        rd(HREG_STATUS, 1'b1, 16'h0000);
        rd(4'hc, 1'b1, 16'h0000);
        $display("test reset done");
        for (int m = 0; m < 2; m++) begin
            four_wire <= m[0];
            wr(HREG_CONFIG, {15'h0, m[0]});
            for (int k = 0; k < 5; k++) begin
                d = $urandom;
                dev(regs[k], d, 16'h0000, 1'b0);
                dev(regs[k], 8'h00, 16'h0000, 1'b1);
                rd(HREG_RDATA, 1'b1, {8'h00, d});
            end
        end
        $display("test single transfers done");
        d = $urandom;
        e = ~d;
        dev(15'h0063, e, 16'h0000, 1'b0);
        dev(15'h0060, d, 16'h0002, 1'b0);
        dev(15'h0062, 8'h00, 16'h0001, 1'b1);
        rd(HREG_RDATA, 1'b1, {8'h00, e});
        dev(15'h0060, 8'h00, 16'h0000, 1'b1);
        rd(HREG_RDATA, 1'b1, {8'h00, d});
        dev(15'h0062, 8'h00, 16'h0000, 1'b1);
        rd(HREG_RDATA, 1'b1, {8'h00, d});
        dev(ADDR_NV_CYCLE_COUNT, d, 16'h0000, 1'b0);
        dev(ADDR_NV_CYCLE_COUNT, 8'h00, 16'h0000, 1'b1);
        rd(HREG_RDATA, 1'b1, 16'h0000);
        $display("test block and read-only done");
        seed = u_spi_dev_model.grst_sets;
        wr(HREG_SEQ, {14'h0, SEQ_RESETS});
        wait_idle();
        chk(16'(u_spi_dev_model.grst_sets - seed), 16'h0001);
        chk({15'h0, u_spi_dev_model.mem[8'h17][6]}, 16'h0000);
        wr(HREG_SEQ, {14'h0, SEQ_SYNC});
        wr(HREG_ADDR, 16'h0055);
        wait_idle();
        rd(HREG_ADDR, 1'b1, {1'b0, ADDR_NV_CYCLE_COUNT});
        chk({14'h0, u_spi_dev_model.mem[8'h19][0], u_spi_dev_model.mem[8'h15][6]}, 16'h0002);
        wr(HREG_SEQ, {14'h0, SEQ_PROGRAM});
        wait_idle();
        chk(16'(u_spi_dev_model.progs), 16'h0001);
        rd(HREG_STATUS, 1'b1, 16'h0006);
        chk({8'h00, u_spi_dev_model.mem[8'hb4]}, {8'h00, NV_LOCK_VALUE});
        chk({8'h00, u_spi_dev_model.mem[8'hab]} & 16'h0047, 16'h0000);
        chk({15'h0, u_spi_dev_model.mem[8'h14][7]}, 16'h0001);
        $display("test sequences done");
        conclude();
    end
endmodule // host_serial_cfg_nvm_access_tb
